// [logic/oc_limit_map.svh]
// Command codes, field positions, reset values and counts for the overcurrent command block
`ifndef OC_LIMIT_MAP_SVH
`define OC_LIMIT_MAP_SVH

`define CMD_CLEAR_FAULTS      8'h03
`define CMD_STORE_ALL         8'h11
`define CMD_RESTORE_ALL       8'h12
`define CMD_OC_FAULT_THRESH   8'h46
`define CMD_OC_FAULT_ACTION   8'h47
`define CMD_OC_WARN_THRESH    8'h4A
`define CMD_STATUS_BYTE       8'h78
`define CMD_STATUS_WORD       8'h79
`define CMD_STATUS_CURRENT    8'h7B
`define CMD_STATUS_COMM       8'h7E

`define LIN_EXPONENT          5'h1F
`define MANT_W                7
`define ACTION_SHUT_POS       7
`define ACTION_RETRY_MSB      5
`define ACTION_RETRY_LSB      3
`define ACTION_DELAY_CODE     3'h7

`define SB_OTHER_POS          0
`define SB_COMM_POS           1
`define SB_OC_FAULT_POS       4
`define SW_CURRENT_POS        14
`define SC_OC_FAULT_POS       7
`define SC_OC_WARN_POS        5
`define SCM_BAD_CMD_POS       7
`define SCM_BAD_DATA_POS      6

`define FAULT_MIN_LARGE       7'h0A
`define FAULT_MAX_LARGE       7'h50
`define FAULT_DEF_LARGE       7'h48
`define FAULT_MIN_SMALL       7'h0A
`define FAULT_MAX_SMALL       7'h48
`define FAULT_DEF_SMALL       7'h30
`define WARN_MIN              7'h08
`define WARN_OFFSET           7'h04
`define SHUT_DEF              1'b1
`define RETRY_DEF             1'b1
`define RESTART_PERIODS       7

`endif

// [logic/oc_limit_pkg.sv]
// Types shared by the overcurrent command block
package oc_limit_pkg;
   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_LATCH = 3'b010,
      ST_RETRY = 3'b100
   } resp_state_t;
   typedef logic [7:0]  cmd_code_t;
   typedef logic [15:0] cmd_word_t;
endpackage

// [logic/oc_limit_regs.sv]
// Overcurrent threshold, fault-action and warning command registers with fault response
//
// How it works
// - Sensed current above fault threshold raises the overcurrent fault.
// - Fault threshold write below warning threshold is rejected, flags bad data, alerts.
// - Warning threshold write above fault threshold is rejected, flags bad data, alerts.
// - Fault threshold reads with fixed exponent minus one, half amp per count.
// - Upper four mantissa bits read zero; only seven low bits are written.
// - Fault threshold range 5..40 A default 36, or 5..36 A default 24.
// - Overcurrent or undervoltage fault applies the action, sets status bits, alerts.
// - Action bits two to zero always read 111.
// - Shutdown bit clear keeps running but flags; set shuts down; default set.
// - Retry 000 latches off until cleared; 111 retries soft-start forever.
// - Action write with retry other than 000 or 111 is rejected and flagged.
// - Only bit 5 of retry is stored and replicated on readback.
// - Current above warning threshold sets warning bits and alerts.
// - Warning threshold loads as stored fault threshold minus 2 A.
// - Store-all command saves fault threshold and action to storage.
// - Warning threshold uses same fixed exponent and seven-bit mantissa format.
`timescale 1ns/1ps
`include "oc_limit_map.svh"

module oc_limit_regs #(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter int RISE_CYCLES   = 2000,
   parameter int SENSE_W       = 8
) (
   input  wire logic                    core_clk,
   input  wire logic                    rstn,
   input  wire logic                    link_clk,
   input  wire logic                    cmd_strobe,
   input  wire logic                    cmd_write,
   input  wire oc_limit_pkg::cmd_code_t cmd_code,
   input  wire oc_limit_pkg::cmd_word_t cmd_wdata,
   output logic                         cmd_busy_r,
   output logic                         rsp_valid_r,
   output oc_limit_pkg::cmd_word_t      rsp_rdata_r,
   input  wire logic [SENSE_W-1:0]      iout_sense,
   input  wire logic                    uv_fault,
   input  wire logic                    power_on_cmd,
   output logic                         power_en_r,
   output logic                         smbalert_o_r,
   output logic                         smbalert_oe_n_r
);
   import oc_limit_pkg::*;

   localparam logic [6:0] FMIN = LARGE_VARIANT ? `FAULT_MIN_LARGE : `FAULT_MIN_SMALL;
   localparam logic [6:0] FMAX = LARGE_VARIANT ? `FAULT_MAX_LARGE : `FAULT_MAX_SMALL;
   localparam logic [6:0] FDEF = LARGE_VARIANT ? `FAULT_DEF_LARGE : `FAULT_DEF_SMALL;
   localparam int RESTART_CYCLES = `RESTART_PERIODS * RISE_CYCLES;
   localparam int CNT_W = $clog2(RESTART_CYCLES + 1);

   initial begin
      if (SENSE_W < `MANT_W || RISE_CYCLES < 1)
         $error("oc_limit_regs: unsupported parameter values");
   end

   function automatic logic retry_ok(input logic [2:0] r);
      retry_ok = (r == 3'h0) || (r == 3'h7);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Link side: capture a command, hand it over by toggle

   logic      req_tgl_r;
   logic      ack_s1_r;
   logic      ack_s2_r;
   logic      ack_seen_r;
   logic      hold_write_r;
   cmd_code_t hold_code_r;
   cmd_word_t hold_wdata_r;
   cmd_word_t rdata_r;
   logic      ack_tgl_r;

   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         ack_s1_r <= ack_tgl_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   // Hold registers stay frozen while busy, so the core may sample them freely
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         req_tgl_r    <= 1'b0;
         hold_write_r <= 1'b0;
         hold_code_r  <= 8'h00;
         hold_wdata_r <= 16'h0000;
         cmd_busy_r   <= 1'b0;
      end else if (cmd_strobe && !cmd_busy_r) begin
         req_tgl_r    <= ~req_tgl_r;
         hold_write_r <= cmd_write;
         hold_code_r  <= cmd_code;
         hold_wdata_r <= cmd_wdata;
         cmd_busy_r   <= 1'b1;
      end else if (ack_s2_r != ack_seen_r) begin
         cmd_busy_r   <= 1'b0;
      end
   end

   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         ack_seen_r  <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= 16'h0000;
      end else begin
         ack_seen_r  <= ack_s2_r;
         rsp_valid_r <= ack_s2_r != ack_seen_r;
         if (ack_s2_r != ack_seen_r)
            rsp_rdata_r <= rdata_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Core side: input synchronisers

   logic               req_s1_r;
   logic               req_s2_r;
   logic               req_seen_r;
   logic [SENSE_W-1:0] sense_s1_r;
   logic [SENSE_W-1:0] sense_s2_r;
   logic               uv_s1_r;
   logic               uv_s2_r;
   logic               on_s1_r;
   logic               on_s2_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         req_s1_r   <= 1'b0;
         req_s2_r   <= 1'b0;
         req_seen_r <= 1'b0;
         sense_s1_r <= '0;
         sense_s2_r <= '0;
         uv_s1_r    <= 1'b0;
         uv_s2_r    <= 1'b0;
         on_s1_r    <= 1'b0;
         on_s2_r    <= 1'b0;
      end else begin
         req_s1_r   <= req_tgl_r;
         req_s2_r   <= req_s1_r;
         req_seen_r <= req_s2_r;
         sense_s1_r <= iout_sense;
         sense_s2_r <= sense_s1_r;
         uv_s1_r    <= uv_fault;
         uv_s2_r    <= uv_s1_r;
         on_s1_r    <= power_on_cmd;
         on_s2_r    <= on_s1_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Command decode

   logic       cmd_go;
   logic [6:0] wmant;
   logic [2:0] wretry;
   logic       wr_fault;
   logic       wr_action;
   logic       wr_warn;
   logic       bad_fault;
   logic       bad_action;
   logic       bad_warn;
   logic       bad_code;
   logic       do_clear;
   logic       do_store;
   logic       do_restore;

   logic [6:0] fault_mant_r;
   logic [6:0] warn_mant_r;
   logic       shut_en_r;
   logic       retry_r;
   logic [6:0] nv_fault_r;
   logic       nv_shut_r;
   logic       nv_retry_r;

   assign cmd_go     = req_s2_r != req_seen_r;
   assign wmant      = hold_wdata_r[`MANT_W-1:0];
   assign wretry     = hold_wdata_r[`ACTION_RETRY_MSB:`ACTION_RETRY_LSB];
   assign wr_fault   = cmd_go && hold_write_r && hold_code_r == `CMD_OC_FAULT_THRESH;
   assign wr_action  = cmd_go && hold_write_r && hold_code_r == `CMD_OC_FAULT_ACTION;
   assign wr_warn    = cmd_go && hold_write_r && hold_code_r == `CMD_OC_WARN_THRESH;
   assign do_clear   = cmd_go && hold_write_r && hold_code_r == `CMD_CLEAR_FAULTS;
   assign do_store   = cmd_go && hold_write_r && hold_code_r == `CMD_STORE_ALL;
   assign do_restore = cmd_go && hold_write_r && hold_code_r == `CMD_RESTORE_ALL;
   assign bad_fault  = wr_fault && (wmant < FMIN || wmant > FMAX || wmant < warn_mant_r);
   assign bad_warn   = wr_warn && (wmant > fault_mant_r || wmant < `WARN_MIN);
   assign bad_action = wr_action && !retry_ok(wretry);
   assign bad_code   = cmd_go && !(hold_code_r inside {`CMD_CLEAR_FAULTS, `CMD_STORE_ALL,
                       `CMD_RESTORE_ALL, `CMD_OC_FAULT_THRESH, `CMD_OC_FAULT_ACTION,
                       `CMD_OC_WARN_THRESH, `CMD_STATUS_BYTE, `CMD_STATUS_WORD,
                       `CMD_STATUS_CURRENT, `CMD_STATUS_COMM});

   //////////////////////////////////////////////////////////////////////////
   // Threshold and action registers with storage copy

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         nv_fault_r <= FDEF;
         nv_shut_r  <= `SHUT_DEF;
         nv_retry_r <= `RETRY_DEF;
      end else if (do_store) begin
         nv_fault_r <= fault_mant_r;
         nv_shut_r  <= shut_en_r;
         nv_retry_r <= retry_r;
      end
   end

   // Rejected writes fall through and keep the old contents
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fault_mant_r <= FDEF;
         warn_mant_r  <= FDEF - `WARN_OFFSET;
         shut_en_r    <= `SHUT_DEF;
         retry_r      <= `RETRY_DEF;
      end else if (do_restore) begin
         fault_mant_r <= nv_fault_r;
         warn_mant_r  <= nv_fault_r - `WARN_OFFSET;
         shut_en_r    <= nv_shut_r;
         retry_r      <= nv_retry_r;
      end else begin
         if (wr_fault && !bad_fault)
            fault_mant_r <= wmant;
         if (wr_warn && !bad_warn)
            warn_mant_r <= wmant;
         if (wr_action && !bad_action) begin
            shut_en_r <= hold_wdata_r[`ACTION_SHUT_POS];
            retry_r   <= wretry[2];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Sticky status flags; a new event beats a clear in the same cycle

   logic oc_evt;
   logic warn_evt;
   logic fault_evt;
   logic oc_fault_f_r;
   logic oc_warn_f_r;
   logic bad_data_f_r;
   logic bad_cmd_f_r;

   assign oc_evt    = sense_s2_r > SENSE_W'(fault_mant_r);
   assign warn_evt  = sense_s2_r > SENSE_W'(warn_mant_r);
   assign fault_evt = oc_evt || uv_s2_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         oc_fault_f_r <= 1'b0;
         oc_warn_f_r  <= 1'b0;
         bad_data_f_r <= 1'b0;
         bad_cmd_f_r  <= 1'b0;
      end else begin
         oc_fault_f_r <= fault_evt || (oc_fault_f_r && !do_clear);
         oc_warn_f_r  <= warn_evt || (oc_warn_f_r && !do_clear);
         bad_data_f_r <= bad_fault || bad_warn || bad_action
                         || (bad_data_f_r && !do_clear);
         bad_cmd_f_r  <= bad_code || (bad_cmd_f_r && !do_clear);
      end
   end

   // Open-drain alert: driven low while any flag stands
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         smbalert_o_r    <= 1'b0;
         smbalert_oe_n_r <= 1'b1;
      end else begin
         smbalert_o_r    <= 1'b0;
         smbalert_oe_n_r <= !(oc_fault_f_r || oc_warn_f_r || bad_data_f_r
                              || bad_cmd_f_r);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Fault response: run, latch off, or wait seven rise periods then restart

   resp_state_t      state_r;
   logic [CNT_W-1:0] wait_cnt_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r    <= ST_RUN;
         wait_cnt_r <= '0;
      end else begin
         case (state_r)
            ST_RUN: begin
               wait_cnt_r <= '0;
               if (fault_evt && shut_en_r && power_en_r)
                  state_r <= retry_r ? ST_RETRY : ST_LATCH;
            end
            ST_LATCH: begin
               if (do_clear)
                  state_r <= ST_RUN;
            end
            ST_RETRY: begin
               // Commanded off ends the retry loop
               if (!on_s2_r || wait_cnt_r == CNT_W'(RESTART_CYCLES - 1)) begin
                  state_r    <= ST_RUN;
                  wait_cnt_r <= '0;
               end else begin
                  wait_cnt_r <= wait_cnt_r + 1'b1;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         power_en_r <= 1'b0;
      else
         power_en_r <= on_s2_r && state_r == ST_RUN
                       && !(fault_evt && shut_en_r && power_en_r);
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data and acknowledge back to the link

   logic [7:0] status_byte;

   always_comb begin
      status_byte = 8'h00;
      status_byte[`SB_OTHER_POS]    = oc_warn_f_r;
      status_byte[`SB_COMM_POS]     = bad_data_f_r || bad_cmd_f_r;
      status_byte[`SB_OC_FAULT_POS] = oc_fault_f_r;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r   <= 16'h0000;
         ack_tgl_r <= 1'b0;
      end else if (cmd_go) begin
         ack_tgl_r <= ~ack_tgl_r;
         rdata_r   <= 16'h0000;
         case (hold_code_r)
            `CMD_OC_FAULT_THRESH: rdata_r <= {`LIN_EXPONENT, 4'h0, fault_mant_r};
            `CMD_OC_WARN_THRESH:  rdata_r <= {`LIN_EXPONENT, 4'h0, warn_mant_r};
            `CMD_OC_FAULT_ACTION: rdata_r <= {8'h00, shut_en_r, 1'b0, {3{retry_r}},
                                              `ACTION_DELAY_CODE};
            `CMD_STATUS_BYTE:     rdata_r <= {8'h00, status_byte};
            `CMD_STATUS_WORD: begin
               rdata_r <= {8'h00, status_byte};
               rdata_r[`SW_CURRENT_POS] <= oc_fault_f_r || oc_warn_f_r;
            end
            `CMD_STATUS_CURRENT: begin
               rdata_r[`SC_OC_FAULT_POS] <= oc_fault_f_r;
               rdata_r[`SC_OC_WARN_POS]  <= oc_warn_f_r;
            end
            `CMD_STATUS_COMM: begin
               rdata_r[`SCM_BAD_CMD_POS]  <= bad_cmd_f_r;
               rdata_r[`SCM_BAD_DATA_POS] <= bad_data_f_r;
            end
            default: rdata_r <= 16'h0000;
         endcase
      end
   end
endmodule

// [testbench/oc_limit_checker.sv]
// Port-level assertions for the overcurrent command block
`timescale 1ns/1ps
module oc_limit_checker #(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter int RISE_CYCLES   = 2000,
   parameter int SENSE_W       = 8
) (
   input wire logic                    core_clk,
   input wire logic                    rstn,
   input wire logic                    link_clk,
   input wire logic                    cmd_strobe,
   input wire logic                    cmd_write,
   input wire oc_limit_pkg::cmd_code_t cmd_code,
   input wire oc_limit_pkg::cmd_word_t cmd_wdata,
   input wire logic                    cmd_busy_r,
   input wire logic                    rsp_valid_r,
   input wire oc_limit_pkg::cmd_word_t rsp_rdata_r,
   input wire logic [SENSE_W-1:0]      iout_sense,
   input wire logic                    uv_fault,
   input wire logic                    power_on_cmd,
   input wire logic                    power_en_r,
   input wire logic                    smbalert_o_r,
   input wire logic                    smbalert_oe_n_r
);
   import oc_limit_pkg::*;
   // Margin of two covers the sync and count edge slack
   localparam int MIN_OFF = 7 * RISE_CYCLES - 2;
   logic [15:0] off_cnt_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         off_cnt_r <= 16'hFFFF;
      end else if (power_en_r) begin
         off_cnt_r <= 16'h0000;
      end else if (off_cnt_r != 16'hFFFF) begin
         off_cnt_r <= off_cnt_r + 16'h0001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   take_busy_a: assert property (@(posedge link_clk) disable iff (!rstn)
      cmd_strobe && !cmd_busy_r |=> cmd_busy_r) else $error("take without busy");
   answer_bound_a: assert property (@(posedge link_clk) disable iff (!rstn)
      $rose(cmd_busy_r) |-> ##[1:12] rsp_valid_r) else $error("no answer");
   valid_pulse_a: assert property (@(posedge link_clk) disable iff (!rstn)
      rsp_valid_r |=> !rsp_valid_r) else $error("answer pulse too long");
   busy_end_a: assert property (@(posedge link_clk) disable iff (!rstn)
      $fell(cmd_busy_r) |-> rsp_valid_r) else $error("busy dropped early");
   rdata_hold_a: assert property (@(posedge link_clk) disable iff (!rstn)
      !rsp_valid_r |-> $stable(rsp_rdata_r)) else $error("read data moved");
   alert_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
      smbalert_o_r == 1'b0) else $error("alert drive value high");
   alert_release_a: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(smbalert_oe_n_r) |-> cmd_busy_r) else $error("alert released without command");
   power_cause_a: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(power_en_r) |-> $past(power_on_cmd, 2)) else $error("power without request");
   shut_alert_a: assert property (@(posedge core_clk) disable iff (!rstn)
      $fell(power_en_r) && power_on_cmd |-> ##[0:3] !smbalert_oe_n_r)
      else $error("shutdown without alert");
   retry_wait_a: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(power_en_r) |-> off_cnt_r >= MIN_OFF) else $error("restart too soon");
endmodule
bind oc_limit_regs oc_limit_checker #(.LARGE_VARIANT(LARGE_VARIANT),
   .RISE_CYCLES(RISE_CYCLES), .SENSE_W(SENSE_W)) u_chk (.core_clk(core_clk),
   .rstn(rstn), .link_clk(link_clk), .cmd_strobe(cmd_strobe), .cmd_write(cmd_write),
   .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_busy_r(cmd_busy_r),
   .rsp_valid_r(rsp_valid_r), .rsp_rdata_r(rsp_rdata_r), .iout_sense(iout_sense),
   .uv_fault(uv_fault), .power_on_cmd(power_on_cmd), .power_en_r(power_en_r),
   .smbalert_o_r(smbalert_o_r), .smbalert_oe_n_r(smbalert_oe_n_r));

// [testbench/pmbus_host_model.sv]
// Host-side model issuing one command at a time on the link
`timescale 1ns/1ps
module pmbus_host_model (
   input wire logic                     link_clk,
   input wire logic                     cmd_busy_r,
   input wire logic                     rsp_valid_r,
   input wire oc_limit_pkg::cmd_word_t  rsp_rdata_r,
   output logic                         cmd_strobe,
   output logic                         cmd_write,
   output oc_limit_pkg::cmd_code_t      cmd_code,
   output oc_limit_pkg::cmd_word_t      cmd_wdata
);
   import oc_limit_pkg::*;
   initial begin
      cmd_strobe = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   task automatic xfer(input logic w, input cmd_code_t c, input cmd_word_t d,
                       output cmd_word_t q);
      int n;
      n = 0;
      @(posedge link_clk);
      #1;
      while (cmd_busy_r !== 1'b0 && n < 40) begin
         @(posedge link_clk);
         #1;
         n++;
      end
      cmd_strobe = 1'b1;
      cmd_write = w;
      cmd_code = c;
      cmd_wdata = d;
      @(posedge link_clk);
      #1;
      // Released lines show the inverse so stale values cannot pass
      cmd_strobe = 1'b0;
      cmd_write = ~w;
      cmd_code = ~c;
      cmd_wdata = ~d;
      while (rsp_valid_r !== 1'b1 && n < 40) begin
         @(posedge link_clk);
         #1;
         n++;
      end
      q = rsp_rdata_r;
   endtask
endmodule

// [testbench/overcurrent_limit_fault_regs_bench.sv]
// Self-checking bench for the overcurrent command block
`timescale 1ns/1ps
`include "oc_limit_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module overcurrent_limit_fault_regs_bench;
   import oc_limit_pkg::*;
   logic      core_clk = 1'b0;
   logic      link_clk = 1'b0;
   logic      rstn = 1'b0;
   logic      cmd_strobe, cmd_write, cmd_busy_r, rsp_valid_r;
   cmd_code_t cmd_code;
   cmd_word_t cmd_wdata, rsp_rdata_r;
   logic [7:0] iout_sense = 8'h10;
   logic      uv_fault = 1'b0;
   logic      power_on_cmd = 1'b1;
   logic      power_en_r, smbalert_o_r, smbalert_oe_n_r;
   int        num_errors = 0;
   int        comparisons = 0;
   int        cycles = 0;
   always #2.5 core_clk = ~core_clk;
   initial begin
      #1.3;
      forever #62.5 link_clk = ~link_clk;
   end
   oc_limit_regs #(.LARGE_VARIANT(1'b1), .RISE_CYCLES(4), .SENSE_W(8)) u_dut (
      .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk), .cmd_strobe(cmd_strobe),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .cmd_busy_r(cmd_busy_r), .rsp_valid_r(rsp_valid_r), .rsp_rdata_r(rsp_rdata_r),
      .iout_sense(iout_sense), .uv_fault(uv_fault), .power_on_cmd(power_on_cmd),
      .power_en_r(power_en_r), .smbalert_o_r(smbalert_o_r),
      .smbalert_oe_n_r(smbalert_oe_n_r));
   pmbus_host_model u_host (.link_clk(link_clk), .cmd_busy_r(cmd_busy_r),
      .rsp_valid_r(rsp_valid_r), .rsp_rdata_r(rsp_rdata_r), .cmd_strobe(cmd_strobe),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic wr(input cmd_code_t c, input cmd_word_t d);
      cmd_word_t q;
      u_host.xfer(1'b1, c, d, q);
   endtask
   task automatic rdchk(input string nm, input cmd_code_t c, input cmd_word_t e);
      cmd_word_t q;
      u_host.xfer(1'b0, c, 16'h0000, q);
      `CHK(nm, e, q)
   endtask
   task automatic rdbit(input string nm, input cmd_code_t c, input int p, input logic e);
      cmd_word_t q;
      u_host.xfer(1'b0, c, 16'h0000, q);
      `CHK(nm, e, q[p])
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic clr();
      wr(`CMD_CLEAR_FAULTS, 16'h0000);
      cyc(4);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge link_clk);
      #1;
      rstn = 1'b1;
      rdchk("fault_thr", `CMD_OC_FAULT_THRESH, 16'hF848);
      rdchk("warn_thr", `CMD_OC_WARN_THRESH, 16'hF844);
      rdchk("action", `CMD_OC_FAULT_ACTION, 16'h00BF);
      `CHK("power_en", 1'b1, power_en_r)
      $display("test reset values done");
      wr(`CMD_OC_FAULT_THRESH, 16'h0A4C);
      rdchk("fault_thr", `CMD_OC_FAULT_THRESH, 16'hF84C);
      wr(`CMD_OC_FAULT_THRESH, 16'hF840);
      rdchk("fault_thr", `CMD_OC_FAULT_THRESH, 16'hF84C);
      rdbit("bad_data", `CMD_STATUS_COMM, `SCM_BAD_DATA_POS, 1'b1);
      rdbit("comm_err", `CMD_STATUS_BYTE, `SB_COMM_POS, 1'b1);
      `CHK("alert_drv", 1'b0, smbalert_o_r)
      `CHK("alert_n", 1'b0, smbalert_oe_n_r)
      clr();
      `CHK("alert_n", 1'b1, smbalert_oe_n_r)
      wr(`CMD_OC_WARN_THRESH, 16'h004D);
      rdchk("warn_thr", `CMD_OC_WARN_THRESH, 16'hF844);
      rdbit("bad_data", `CMD_STATUS_COMM, `SCM_BAD_DATA_POS, 1'b1);
      clr();
      wr(`CMD_OC_WARN_THRESH, 16'h003C);
      rdchk("warn_thr", `CMD_OC_WARN_THRESH, 16'hF83C);
      wr(`CMD_OC_FAULT_THRESH, 16'h0051);
      rdchk("fault_thr", `CMD_OC_FAULT_THRESH, 16'hF84C);
      rdchk("unknown", 8'h20, 16'h0000);
      rdbit("bad_cmd", `CMD_STATUS_COMM, `SCM_BAD_CMD_POS, 1'b1);
      clr();
      $display("test thresholds done");
      for (int i = 1; i < 7; i++) begin
         wr(`CMD_OC_FAULT_ACTION, {8'h00, 2'b10, i[2:0], 3'b000});
         rdchk("action", `CMD_OC_FAULT_ACTION, 16'h00BF);
         rdbit("bad_data", `CMD_STATUS_COMM, `SCM_BAD_DATA_POS, 1'b1);
         clr();
      end
      wr(`CMD_OC_FAULT_ACTION, 16'h0040);
      rdchk("action", `CMD_OC_FAULT_ACTION, 16'h0007);
      $display("test action codes done");
      iout_sense = 8'h50;
      cyc(10);
      `CHK("power_en", 1'b1, power_en_r)
      rdbit("oc_fault", `CMD_STATUS_CURRENT, `SC_OC_FAULT_POS, 1'b1);
      rdbit("oc_warn", `CMD_STATUS_CURRENT, `SC_OC_WARN_POS, 1'b1);
      rdbit("byte_fault", `CMD_STATUS_BYTE, `SB_OC_FAULT_POS, 1'b1);
      rdbit("byte_other", `CMD_STATUS_BYTE, `SB_OTHER_POS, 1'b1);
      rdbit("word_cur", `CMD_STATUS_WORD, `SW_CURRENT_POS, 1'b1);
      iout_sense = 8'h10;
      cyc(10);
      rdbit("oc_fault", `CMD_STATUS_CURRENT, `SC_OC_FAULT_POS, 1'b1);
      `CHK("alert_n", 1'b0, smbalert_oe_n_r)
      clr();
      `CHK("alert_n", 1'b1, smbalert_oe_n_r)
      $display("test ignore response done");
      wr(`CMD_OC_FAULT_ACTION, 16'h0080);
      iout_sense = 8'h50;
      cyc(10);
      iout_sense = 8'h10;
      cyc(200);
      `CHK("power_en", 1'b0, power_en_r)
      clr();
      cyc(10);
      `CHK("power_en", 1'b1, power_en_r)
      wr(`CMD_OC_FAULT_ACTION, 16'h00B8);
      iout_sense = 8'h50;
      cyc(6);
      iout_sense = 8'h10;
      cyc(14);
      `CHK("power_en", 1'b0, power_en_r)
      cyc(30);
      `CHK("power_en", 1'b1, power_en_r)
      clr();
      uv_fault = 1'b1;
      cyc(6);
      uv_fault = 1'b0;
      rdbit("byte_fault", `CMD_STATUS_BYTE, `SB_OC_FAULT_POS, 1'b1);
      cyc(60);
      clr();
      // Output held off long enough that a restart is not mistaken for a quick retry
      power_on_cmd = 1'b0;
      cyc(6);
      `CHK("power_en", 1'b0, power_en_r)
      cyc(40);
      power_on_cmd = 1'b1;
      cyc(6);
      `CHK("power_en", 1'b1, power_en_r)
      $display("test shutdown modes done");
      wr(`CMD_OC_WARN_THRESH, 16'h0020);
      wr(`CMD_OC_FAULT_THRESH, 16'h0030);
      wr(`CMD_OC_FAULT_ACTION, 16'h0080);
      wr(`CMD_STORE_ALL, 16'h0000);
      wr(`CMD_OC_FAULT_THRESH, 16'h0040);
      wr(`CMD_OC_FAULT_ACTION, 16'h00B8);
      wr(`CMD_RESTORE_ALL, 16'h0000);
      rdchk("fault_thr", `CMD_OC_FAULT_THRESH, 16'hF830);
      rdchk("warn_thr", `CMD_OC_WARN_THRESH, 16'hF82C);
      rdchk("action", `CMD_OC_FAULT_ACTION, 16'h0087);
      $display("test store restore done");
      conclude();
   end
endmodule
